// *** hw/evtctl_defines.vh ***
// Register offsets, reset values and field layout of the event controller
// What this block does
// - Nine general levels, numbered 7 to 15
// - Fixed priority by level, zero highest
// - Higher event may nest over active ones
// - Sources routed through rewritable assignment registers
// - Default source routing onto levels 7 to 13
// - Latch, mask, pending are 16-bit registers
// - Latch sets/clears; writes only where masked
// - Mask bit set lets latched event through
// - Global enable for general levels, two instructions
// - Pending marks active or nested events, read-only
// - System mask, status, wakeup: 32-bit registers
// - System mask bit passes or blocks source
// - Status bit shows source asserting now
// - Enabled source wakes idle core
// - Pending bits serve as the acknowledgement
// - Latch sets on NMI and general-level rising edges, two-cycle detect
// - Pending set clears latch, next edge queued
// - Pending no sooner than three cycles after edge
// - Return address kept per event, state saved
// - Registers reachable in supervisor mode only
// - Nonmaskable event from watchdog or pin
`ifndef EVTCTL_DEFINES_VH
`define EVTCTL_DEFINES_VH

`define OFS_CORE_LATCH      8'h00
`define OFS_CORE_MASK       8'h04
`define OFS_CORE_PENDING    8'h08
`define OFS_SYS_MASK        8'h0C
`define OFS_SYS_STATUS      8'h10
`define OFS_SYS_WAKE        8'h14
`define OFS_ASSIGN0         8'h18
`define OFS_ASSIGN1         8'h1C
`define OFS_ASSIGN2         8'h20
`define OFS_ASSIGN3         8'h24
`define OFS_GLOBAL_EN       8'h28

`define RST_ASSIGN0         32'h10000000
`define RST_ASSIGN1         32'h33322221
`define RST_ASSIGN2         32'h66655444
`define RST_ASSIGN3         32'h00000000

`define LVL_EMU             4'h0
`define LVL_RESET           4'h1
`define LVL_NMI             4'h2
`define LVL_EXC             4'h3
`define LVL_HWERR           4'h5
`define LVL_TIMER           4'h6
`define LVL_GEN_FIRST       4'h7
`define FIXED_UNMASKED      16'h001F
`define NO_EVENT            5'h10

`endif

// *** hw/two_stage_event_controller.v ***
// Two-stage event controller: source routing stage and core event stage
`timescale 1ns/10ps
`include "evtctl_defines.vh"

module two_stage_event_controller #(
	parameter NUM_SRC = 32,
	parameter NUM_GEN = 9
) (
	input  wire        i_sys_clk,
	input  wire        i_rst,
	input  wire [31:0] i_src_irq,
	input  wire        i_nmi_pin,
	input  wire        i_wdog_nmi,
	input  wire        i_emu_evt,
	input  wire        i_reset_evt,
	input  wire        i_exc_evt,
	input  wire        i_hwerr_evt,
	input  wire        i_timer_evt,
	input  wire        i_core_idle,
	input  wire        i_global_enable_instr,
	input  wire        i_global_disable_instr,
	input  wire        i_event_return,
	input  wire [31:0] i_resume_addr,
	input  wire        i_reg_sel,
	input  wire        i_reg_we,
	input  wire        i_supervisor,
	input  wire [7:0]  i_reg_addr,
	input  wire [31:0] i_reg_wdata,
	output reg         o_event_take,
	output reg  [3:0]  o_event_level,
	output reg         o_return_valid,
	output reg  [31:0] o_return_addr,
	output reg  [15:0] o_pending,
	output reg         o_wakeup,
	output reg         o_global_enable,
	output reg  [31:0] o_reg_rdata,
	output reg         o_reg_ack
);

	// Lowest set bit index; bit 4 high when none is set
	function [4:0] first_set;
		input [15:0] v;
		integer j;
		begin
			first_set = `NO_EVENT;
			for (j = 15; j >= 0; j = j - 1) begin
				if (v[j])
					first_set = {1'b0, j[3:0]};
			end
		end
	endfunction

	// Synchronisers for asynchronous pins
	reg [31:0] src_s1_reg;
	reg [31:0] src_s2_reg;
	reg        nmi_s1_reg;
	reg        nmi_s2_reg;

	// System routing stage state
	reg [31:0] sys_mask_reg;
	reg [31:0] sys_wake_reg;
	reg [31:0] assign_reg [0:3];
	reg [NUM_GEN-1:0] gen_in_reg;
	reg [NUM_GEN-1:0] gen_prev_reg;
	reg [NUM_GEN-1:0] gen_edge_reg;
	reg        nmi_prev_reg;
	reg        nmi_edge_reg;

	// Core event stage state
	reg [15:0] latch_reg;
	reg [15:0] mask_reg;
	reg [15:0] pending_reg;
	reg        gen_enable_reg;
	reg [31:0] ret_addr_mem [0:15];

	reg [NUM_GEN-1:0] gen_in_next;
	reg [15:0] latch_next;
	reg [15:0] pending_next;
	reg [15:0] set_vec;
	reg [15:0] eff_mask;
	reg [3:0]  fld;
	reg [31:0] rdata_next;
	reg        take;
	integer    i;
	integer    k;

	wire [4:0] cand;
	wire [4:0] act;
	wire       wr_ok;
	wire [31:0] src_active;
	wire        hit_core_latch;
	wire        hit_core_mask;
	wire        hit_sys_mask;
	wire        hit_sys_wake;
	wire        hit_assign0;
	wire        hit_assign1;
	wire        hit_assign2;
	wire        hit_assign3;

	assign src_active = src_s2_reg & sys_mask_reg;
	assign wr_ok      = i_reg_sel & i_reg_we & i_supervisor;

	// Writable register decode
	assign hit_core_latch = (i_reg_addr == `OFS_CORE_LATCH);
	assign hit_core_mask  = (i_reg_addr == `OFS_CORE_MASK);
	assign hit_sys_mask   = (i_reg_addr == `OFS_SYS_MASK);
	assign hit_sys_wake   = (i_reg_addr == `OFS_SYS_WAKE);
	assign hit_assign0    = (i_reg_addr == `OFS_ASSIGN0);
	assign hit_assign1    = (i_reg_addr == `OFS_ASSIGN1);
	assign hit_assign2    = (i_reg_addr == `OFS_ASSIGN2);
	assign hit_assign3    = (i_reg_addr == `OFS_ASSIGN3);

	// Source pins, two flops
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			src_s1_reg <= 32'h00000000;
			src_s2_reg <= 32'h00000000;
		end else begin
			src_s1_reg <= i_src_irq;
			src_s2_reg <= src_s1_reg;
		end
	end

	// Nonmaskable pin, two flops
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			nmi_s1_reg <= 1'b0;
			nmi_s2_reg <= 1'b0;
		end else begin
			nmi_s1_reg <= i_nmi_pin;
			nmi_s2_reg <= nmi_s1_reg;
		end
	end

	// Route each unmasked source onto its assigned general input
	always @* begin
		gen_in_next = {NUM_GEN{1'b0}};
		fld         = 4'h0;
		for (i = 0; i < NUM_SRC; i = i + 1) begin
			fld = assign_reg[i >> 3][(i & 7) * 4 +: 4];
			for (k = 0; k < NUM_GEN; k = k + 1) begin
				if (src_active[i] && (fld == k[3:0]))
					gen_in_next[k] = 1'b1;
			end
		end
	end

	// Two-cycle rising edge detection on the general inputs
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			gen_in_reg   <= {NUM_GEN{1'b0}};
			gen_prev_reg <= {NUM_GEN{1'b0}};
			gen_edge_reg <= {NUM_GEN{1'b0}};
			nmi_prev_reg <= 1'b0;
			nmi_edge_reg <= 1'b0;
		end else begin
			gen_in_reg   <= gen_in_next;
			gen_prev_reg <= gen_in_reg;
			gen_edge_reg <= gen_in_reg & ~gen_prev_reg;
			nmi_prev_reg <= nmi_s2_reg | i_wdog_nmi;
			nmi_edge_reg <= (nmi_s2_reg | i_wdog_nmi) & ~nmi_prev_reg;
		end
	end

	// Levels 0..3 cannot be masked, level 4 is always masked; general levels also need the global enable
	always @* begin
		eff_mask      = mask_reg | `FIXED_UNMASKED;
		eff_mask[4]   = 1'b0;
		eff_mask[15:7] = mask_reg[15:7] & {NUM_GEN{gen_enable_reg}};
	end

	assign cand = first_set(latch_reg & eff_mask);
	assign act  = first_set(pending_reg);

	// Core event stage next state
	always @* begin
		set_vec        = 16'h0000;
		set_vec[0]     = i_emu_evt;
		set_vec[1]     = i_reset_evt;
		set_vec[2]     = nmi_edge_reg;
		set_vec[3]     = i_exc_evt;
		set_vec[5]     = i_hwerr_evt;
		set_vec[6]     = i_timer_evt;
		set_vec[15:7]  = gen_edge_reg;
		// Accept only an event that outranks everything already active
		take = ~cand[4] & (act[4] | (cand[3:0] < act[3:0]));
		latch_next   = latch_reg;
		pending_next = pending_reg;
		if (wr_ok && hit_core_latch)
			latch_next = (latch_reg & (mask_reg | `FIXED_UNMASKED))
				| (i_reg_wdata[15:0] & ~(mask_reg | `FIXED_UNMASKED));
		if (i_event_return && !act[4])
			pending_next[act[3:0]] = 1'b0;
		if (take) begin
			pending_next[cand[3:0]] = 1'b1;
			latch_next[cand[3:0]]   = 1'b0;
		end
		// A fresh edge wins over the clear in the same cycle
		latch_next = latch_next | set_vec;
	end

	// Latch and pending registers
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			latch_reg   <= 16'h0000;
			pending_reg <= 16'h0000;
		end else begin
			latch_reg   <= latch_next;
			pending_reg <= pending_next;
		end
	end

	// Entry and return strobes toward the sequencer
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_event_take   <= 1'b0;
			o_event_level  <= 4'h0;
			o_return_valid <= 1'b0;
			o_return_addr  <= 32'h00000000;
		end else begin
			o_event_take   <= take;
			o_event_level  <= take ? cand[3:0] : o_event_level;
			o_return_valid <= i_event_return & ~act[4];
			if (i_event_return && !act[4])
				o_return_addr <= ret_addr_mem[act[3:0]];
		end
	end

	// Resume address saved per level on entry
	always @(posedge i_sys_clk) begin
		if (take)
			ret_addr_mem[cand[3:0]] <= i_resume_addr;
	end

	// Global enable; disable wins
	always @(posedge i_sys_clk) begin
		if (i_rst)
			gen_enable_reg <= 1'b0;
		else if (i_global_disable_instr)
			gen_enable_reg <= 1'b0;
		else if (i_global_enable_instr)
			gen_enable_reg <= 1'b1;
	end

	// Software-written registers
	always @(posedge i_sys_clk) begin
		if (i_rst)
			mask_reg <= 16'h0000;
		else if (wr_ok && hit_core_mask)
			mask_reg <= i_reg_wdata[15:0] & ~`FIXED_UNMASKED;
	end

	// System mask and wakeup enable
	always @(posedge i_sys_clk) begin
		if (i_rst)
			sys_mask_reg <= 32'h00000000;
		else if (wr_ok && hit_sys_mask)
			sys_mask_reg <= i_reg_wdata;
	end

	always @(posedge i_sys_clk) begin
		if (i_rst)
			sys_wake_reg <= 32'h00000000;
		else if (wr_ok && hit_sys_wake)
			sys_wake_reg <= i_reg_wdata;
	end

	// Routing starts from the default map
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			assign_reg[0] <= `RST_ASSIGN0;
			assign_reg[1] <= `RST_ASSIGN1;
			assign_reg[2] <= `RST_ASSIGN2;
			assign_reg[3] <= `RST_ASSIGN3;
		end else if (wr_ok) begin
			if (hit_assign0)
				assign_reg[0] <= i_reg_wdata;
			else if (hit_assign1)
				assign_reg[1] <= i_reg_wdata;
			else if (hit_assign2)
				assign_reg[2] <= i_reg_wdata;
			else if (hit_assign3)
				assign_reg[3] <= i_reg_wdata;
		end
	end

	// Read mux; outside supervisor mode the space reads as zero
	always @* begin
		rdata_next = 32'h00000000;
		if (!i_supervisor)
			rdata_next = 32'h00000000;
		else if (i_reg_addr == `OFS_CORE_LATCH)
			rdata_next = {16'h0000, latch_reg};
		else if (i_reg_addr == `OFS_CORE_MASK)
			rdata_next = {16'h0000, mask_reg | `FIXED_UNMASKED};
		else if (i_reg_addr == `OFS_CORE_PENDING)
			rdata_next = {16'h0000, pending_reg};
		else if (i_reg_addr == `OFS_SYS_MASK)
			rdata_next = sys_mask_reg;
		else if (i_reg_addr == `OFS_SYS_STATUS)
			rdata_next = src_s2_reg;
		else if (i_reg_addr == `OFS_SYS_WAKE)
			rdata_next = sys_wake_reg;
		else if (i_reg_addr == `OFS_ASSIGN0)
			rdata_next = assign_reg[0];
		else if (i_reg_addr == `OFS_ASSIGN1)
			rdata_next = assign_reg[1];
		else if (i_reg_addr == `OFS_ASSIGN2)
			rdata_next = assign_reg[2];
		else if (i_reg_addr == `OFS_ASSIGN3)
			rdata_next = assign_reg[3];
		else if (i_reg_addr == `OFS_GLOBAL_EN)
			rdata_next = {31'h00000000, gen_enable_reg};
	end

	// Register port answer
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h00000000;
			o_reg_ack   <= 1'b0;
		end else begin
			o_reg_rdata <= i_reg_sel ? rdata_next : 32'h00000000;
			o_reg_ack   <= i_reg_sel;
		end
	end

	// Pending copy toward the sequencer
	always @(posedge i_sys_clk) begin
		if (i_rst)
			o_pending <= 16'h0000;
		else
			o_pending <= pending_next;
	end

	// Wake request and global enable status
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_wakeup        <= 1'b0;
			o_global_enable <= 1'b0;
		end else begin
			o_wakeup        <= i_core_idle & |(src_s2_reg & sys_wake_reg);
			o_global_enable <= gen_enable_reg;
		end
	end

endmodule // two_stage_event_controller

// *** tb/evtctl_props.sv ***
// Port-level assertions for the two-stage event controller
`timescale 1ns/10ps
module evtctl_props (
	input wire        i_sys_clk,
	input wire        i_rst,
	input wire        i_global_enable_instr,
	input wire        i_global_disable_instr,
	input wire        i_core_idle,
	input wire        i_reg_sel,
	input wire        i_supervisor,
	input wire        o_event_take,
	input wire [3:0]  o_event_level,
	input wire        o_return_valid,
	input wire [15:0] o_pending,
	input wire        o_wakeup,
	input wire        o_global_enable,
	input wire [31:0] o_reg_rdata,
	input wire        o_reg_ack
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_user_acc;
		i_reg_sel && !i_supervisor;
	endsequence
	sequence s_take_gen;
		o_event_take && o_event_level >= 4'h7;
	endsequence
	chk_ack_follows: assert property (i_reg_sel |=> o_reg_ack)
		else $error("ack missing");
	chk_ack_idle: assert property (!i_reg_sel |=> !o_reg_ack && o_reg_rdata == 32'h0)
		else $error("ack or data without access");
	chk_user_zero: assert property (s_user_acc |=> o_reg_rdata == 32'h0)
		else $error("user mode read not zero");
	chk_take_pend: assert property (o_event_take |-> o_pending[o_event_level])
		else $error("taken level not pending");
	chk_take_prio: assert property (o_event_take |->
		($past(o_pending) & ((16'h2 << o_event_level) - 16'h1)) == 16'h0)
		else $error("take below active level");
	chk_gen_global: assert property (s_take_gen |-> o_global_enable)
		else $error("general take while disabled");
	chk_disable_wins: assert property (i_global_disable_instr |=> ##1 !o_global_enable)
		else $error("disable ignored");
	chk_enable_sets: assert property (i_global_enable_instr && !i_global_disable_instr
		|=> ##1 o_global_enable)
		else $error("enable ignored");
	chk_return_pops: assert property (o_return_valid && !o_event_take |->
		$countones(o_pending) < $countones($past(o_pending)))
		else $error("return kept pending");
	chk_wake_idle: assert property (o_wakeup |-> $past(i_core_idle))
		else $error("wakeup while busy");
endmodule // evtctl_props

bind two_stage_event_controller evtctl_props evtctl_props_i (.*);

// *** tb/seq_model.sv ***
// Sequencer model: answers the latest accepted event with a return; a new take restarts the count
`timescale 1ns/10ps
module seq_model (
	input  wire        i_sys_clk,
	input  wire        i_rst,
	input  wire        i_take,
	input  wire        i_slow,
	output reg         o_ret,
	output reg  [31:0] o_addr
);
	reg [3:0] cnt_reg;
	always @(posedge i_sys_clk) begin
		o_ret <= 1'b0;
		if (i_rst) begin
			cnt_reg <= 4'h0;
			o_addr <= 32'h0;
		end else if (i_take) begin
			cnt_reg <= i_slow ? 4'hC : 4'h2;
			o_addr <= o_addr + 32'h4;
		end else if (cnt_reg == 4'h1) begin
			cnt_reg <= 4'h0;
			o_ret <= 1'b1;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule // seq_model

// *** tb/tb.sv ***
// Self-checking bench for the two-stage event controller
`timescale 1ns/10ps
`include "evtctl_defines.vh"
module tb;
	reg         i_sys_clk = 1'b0;
	reg         i_rst = 1'b1;
	reg  [31:0] i_src_irq = 32'h0;
	reg  [6:0]  ev = 7'h0;
	reg         i_core_idle = 1'b0;
	reg         i_global_enable_instr = 1'b0;
	reg         i_global_disable_instr = 1'b0;
	reg         i_reg_sel = 1'b0;
	reg         i_reg_we = 1'b0;
	reg         i_supervisor = 1'b1;
	reg  [7:0]  i_reg_addr = 8'h0;
	reg  [31:0] i_reg_wdata = 32'h0;
	reg         slow = 1'b0;
	wire        i_emu_evt = ev[0];
	wire        i_reset_evt = ev[1];
	wire        i_nmi_pin = ev[2];
	wire        i_wdog_nmi = ev[3];
	wire        i_exc_evt = ev[4];
	wire        i_hwerr_evt = ev[5];
	wire        i_timer_evt = ev[6];
	wire        i_event_return;
	wire [31:0] i_resume_addr;
	wire        o_event_take, o_return_valid, o_wakeup, o_global_enable, o_reg_ack;
	wire [3:0]  o_event_level;
	wire [31:0] o_return_addr, o_reg_rdata;
	wire [15:0] o_pending;
	integer     fails = 0, tests_run = 0, cyc = 0, seed, i, k;
	reg  [31:0] rd;
	reg  [31:0] ret_stk [0:15];
	integer     sp = 0;
	two_stage_event_controller two_stage_event_controller_i (.*);
	seq_model seq_model_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_take(o_event_take),
		.i_slow(slow), .o_ret(i_event_return), .o_addr(i_resume_addr));
	always #4 i_sys_clk = ~i_sys_clk;
	// Saved resume address per accepted event, popped on return
	always @(posedge i_sys_clk) begin
		#1;
		if (o_return_valid && sp > 0) begin
			sp = sp - 1;
			chk("retaddr", ret_stk[sp], o_return_addr);
		end
		if (o_event_take && sp < 16) begin
			ret_stk[sp] = i_resume_addr;
			sp = sp + 1;
		end
	end
	function [31:0] rv(input integer r);
		case (r)
			1: rv = 32'h1F;
			6: rv = `RST_ASSIGN0;
			7: rv = `RST_ASSIGN1;
			8: rv = `RST_ASSIGN2;
			9: rv = `RST_ASSIGN3;
			default: rv = 32'h0;
		endcase
	endfunction
	function [3:0] lvl(input integer s);
		lvl = s < 7 ? 7 : s < 9 ? 8 : s < 13 ? 9 : s < 16 ? 10 : s < 19 ? 11 : s < 21 ? 12 : 13;
	endfunction
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task acc(input s, input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge i_sys_clk);
			i_reg_sel <= 1'b1;
			i_supervisor <= s;
			i_reg_we <= w;
			i_reg_addr <= a;
			i_reg_wdata <= d;
			@(posedge i_sys_clk);
			i_reg_sel <= 1'b0;
			#1 rd = o_reg_rdata;
		end
	endtask
	task take(input [3:0] l);
		integer n;
		begin
			n = 0;
			while (o_event_take !== 1'b1 && n < 40) begin
				@(posedge i_sys_clk);
				#1 n = n + 1;
			end
			chk("take", {27'h1, l}, {27'h0, o_event_take, o_event_level});
			while (o_pending !== 16'h0 && n < 80) begin
				@(posedge i_sys_clk);
				#1 n = n + 1;
			end
			chk("pend", 32'h0, {16'h0, o_pending});
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	always @(posedge i_sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			wrap_up;
		end
	end
	initial begin
		seed = 32'h1F26675D;
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		for (i = 0; i < 11; i = i + 1) begin
			acc(1'b1, 1'b0, i * 4, 32'h0);
			chk("reset", rv(i), rd);
		end
		acc(1'b1, 1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		acc(1'b0, 1'b1, `OFS_SYS_MASK, 32'hFFFFFFFF);
		acc(1'b0, 1'b0, `OFS_CORE_MASK, 32'h0);
		chk("user", 32'h0, rd);
		acc(1'b1, 1'b0, `OFS_SYS_MASK, 32'h0);
		chk("userwr", 32'h0, rd);
		acc(1'b1, 1'b1, `OFS_SYS_MASK, 32'hFFFFFFFF);
		acc(1'b1, 1'b1, `OFS_SYS_WAKE, 32'h1);
		@(posedge i_sys_clk);
		i_global_enable_instr <= 1'b1;
		i_core_idle <= 1'b1;
		i_src_irq <= 32'h1;
		@(posedge i_sys_clk);
		i_global_enable_instr <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		#1 chk("wake", 32'h1, {31'h0, o_wakeup});
		acc(1'b1, 1'b0, `OFS_CORE_LATCH, 32'h0);
		chk("latch", 32'h80, rd);
		acc(1'b1, 1'b1, `OFS_CORE_LATCH, 32'h0);
		acc(1'b1, 1'b0, `OFS_CORE_LATCH, 32'h0);
		chk("latchwr", 32'h0, rd);
		@(posedge i_sys_clk);
		i_src_irq <= 32'h0;
		i_core_idle <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		i_src_irq <= 32'h1;
		repeat (8) @(posedge i_sys_clk);
		acc(1'b1, 1'b1, `OFS_CORE_MASK, 32'hFFFF);
		take(4'h7);
		for (i = 0; i < 8; i = i + 1) begin
			k = i == 0 ? 23 : $unsigned($random(seed)) % 24;
			@(posedge i_sys_clk);
			slow <= $random(seed);
			i_src_irq <= 32'h1 << k;
			take(lvl(k));
			acc(1'b1, 1'b0, `OFS_SYS_STATUS, 32'h0);
			chk("status", 32'h1 << k, rd);
			i_src_irq <= 32'h0;
		end
		acc(1'b1, 1'b1, `OFS_ASSIGN2, 32'h66655448);
		@(posedge i_sys_clk);
		i_src_irq <= 32'h10000;
		take(4'hF);
		i_src_irq <= 32'h0;
		for (i = 0; i < 7; i = i + 1) begin
			@(posedge i_sys_clk);
			ev <= 7'h1 << i;
			@(posedge i_sys_clk);
			ev <= 7'h0;
			take(i < 2 ? i : i < 4 ? 2 : i == 4 ? 3 : i);
		end
		@(posedge i_sys_clk);
		i_global_disable_instr <= 1'b1;
		i_global_enable_instr <= 1'b1;
		@(posedge i_sys_clk);
		i_global_disable_instr <= 1'b0;
		i_global_enable_instr <= 1'b0;
		@(posedge i_sys_clk);
		#1 chk("glob", 32'h0, {31'h0, o_global_enable});
		wrap_up;
	end
endmodule // tb
